// *** rtl/jdbl_defines.vh ***
// jdbl_defines.vh: constants of the test-port debug and loader access block
// assumes: included by bare name from every design file of the block but the synchroniser
`ifndef JDBL_DEFINES_VH
`define JDBL_DEFINES_VH

// test access port states, one-hot
`define JDBL_ST_TLR       16'h0001
`define JDBL_ST_RTI       16'h0002
`define JDBL_ST_SEL_DR    16'h0004
`define JDBL_ST_CAP_DR    16'h0008
`define JDBL_ST_SH_DR     16'h0010
`define JDBL_ST_EX1_DR    16'h0020
`define JDBL_ST_PAUSE_DR  16'h0040
`define JDBL_ST_EX2_DR    16'h0080
`define JDBL_ST_UPD_DR    16'h0100
`define JDBL_ST_SEL_IR    16'h0200
`define JDBL_ST_CAP_IR    16'h0400
`define JDBL_ST_SH_IR     16'h0800
`define JDBL_ST_EX1_IR    16'h1000
`define JDBL_ST_PAUSE_IR  16'h2000
`define JDBL_ST_EX2_IR    16'h4000
`define JDBL_ST_UPD_IR    16'h8000

// instruction register
`define JDBL_IR_W         4
`define JDBL_IR_CAPTURE   4'h1
`define JDBL_IR_SYSPROG   4'h2
`define JDBL_IR_SPE       4'h3
`define JDBL_IR_PASSWORD  4'h4
`define JDBL_IR_DEBUG     4'h5
`define JDBL_IR_BYPASS    4'hf

// data register layout
`define JDBL_DR_W         37
`define JDBL_PW_LEN       18
`define JDBL_PW_WORDS     16
`define JDBL_PW_LAST      4'hf
`define JDBL_AREA_SYSTEM  2'h0
`define JDBL_AREA_ULOADER 2'h1
`define JDBL_AREA_APP     2'h2
`define JDBL_AREA_NONE    2'h3

// debug command: [36:34] op, [33:32] space, [31:16] address, [15:0] data
`define JDBL_OP_NOP       3'h0
`define JDBL_OP_READ      3'h1
`define JDBL_OP_WRITE     3'h2
`define JDBL_OP_STEP      3'h3
`define JDBL_OP_HALT      3'h4
`define JDBL_OP_RESUME    3'h5
`define JDBL_SP_REG       2'h0
`define JDBL_SP_MEM       2'h1
`define JDBL_SP_PRIV      2'h2
`define JDBL_SP_BREAK     2'h3
`define JDBL_BP_OFF       2'h3

// system memory area as seen by debug memory accesses
`define JDBL_SYS_BASE     16'h8000
`define JDBL_SYS_LIMIT    16'h9fff

`endif

// *** rtl/jdbl_sync.v ***
// jdbl_sync.v: two-stage synchroniser for a group of pin inputs
// assumes: inputs come from outside the i_clk domain
module jdbl_sync
#(
  parameter W = 1
)
(
  input  wire         i_clk,
  input  wire         i_reset_n,
  input  wire [W-1:0] i_async,
  output reg  [W-1:0] o_sync
);

  reg [W-1:0] meta;

  always @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      meta   <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end
    else
    begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule // jdbl_sync

// *** rtl/jdbl_tap_fsm.v ***
// jdbl_tap_fsm.v: sixteen-state test access port controller
// assumes: i_adv is a one-cycle pulse at each rising test clock edge
`include "jdbl_defines.vh"
module jdbl_tap_fsm
(
  input  wire        i_clk,
  input  wire        i_reset_n,
  input  wire        i_adv,
  input  wire        i_tms,
  input  wire        i_trst_n,
  output reg  [15:0] o_state
);

  reg [15:0] next_state;

  always @*
  begin
    case (o_state)
      `JDBL_ST_TLR:      next_state = i_tms ? `JDBL_ST_TLR      : `JDBL_ST_RTI;
      `JDBL_ST_RTI:      next_state = i_tms ? `JDBL_ST_SEL_DR   : `JDBL_ST_RTI;
      `JDBL_ST_SEL_DR:   next_state = i_tms ? `JDBL_ST_SEL_IR   : `JDBL_ST_CAP_DR;
      `JDBL_ST_CAP_DR:   next_state = i_tms ? `JDBL_ST_EX1_DR   : `JDBL_ST_SH_DR;
      `JDBL_ST_SH_DR:    next_state = i_tms ? `JDBL_ST_EX1_DR   : `JDBL_ST_SH_DR;
      `JDBL_ST_EX1_DR:   next_state = i_tms ? `JDBL_ST_UPD_DR   : `JDBL_ST_PAUSE_DR;
      `JDBL_ST_PAUSE_DR: next_state = i_tms ? `JDBL_ST_EX2_DR   : `JDBL_ST_PAUSE_DR;
      `JDBL_ST_EX2_DR:   next_state = i_tms ? `JDBL_ST_UPD_DR   : `JDBL_ST_SH_DR;
      `JDBL_ST_UPD_DR:   next_state = i_tms ? `JDBL_ST_SEL_DR   : `JDBL_ST_RTI;
      `JDBL_ST_SEL_IR:   next_state = i_tms ? `JDBL_ST_TLR      : `JDBL_ST_CAP_IR;
      `JDBL_ST_CAP_IR:   next_state = i_tms ? `JDBL_ST_EX1_IR   : `JDBL_ST_SH_IR;
      `JDBL_ST_SH_IR:    next_state = i_tms ? `JDBL_ST_EX1_IR   : `JDBL_ST_SH_IR;
      `JDBL_ST_EX1_IR:   next_state = i_tms ? `JDBL_ST_UPD_IR   : `JDBL_ST_PAUSE_IR;
      `JDBL_ST_PAUSE_IR: next_state = i_tms ? `JDBL_ST_EX2_IR   : `JDBL_ST_PAUSE_IR;
      `JDBL_ST_EX2_IR:   next_state = i_tms ? `JDBL_ST_UPD_IR   : `JDBL_ST_SH_IR;
      `JDBL_ST_UPD_IR:   next_state = i_tms ? `JDBL_ST_SEL_DR   : `JDBL_ST_RTI;
      default:           next_state = `JDBL_ST_TLR;
    endcase
  end

  always @(posedge i_clk)
  begin
    if (!i_reset_n || !i_trst_n)
      o_state <= `JDBL_ST_TLR;
    else if (i_adv)
      o_state <= next_state;
  end

endmodule // jdbl_tap_fsm

// *** rtl/jdbl_top.v ***
// jdbl_top.v: test-port debug engine, loader entry and loader password gate
// assumes: test pins are asynchronous to i_clk and are sampled here; cpu,
// loader and password memory signals are on i_clk; i_pw_word answers
// o_pw_area/o_pw_index combinationally in the same cycle
// Function
// - the loader is refused each memory area until that area's own password is given.
// - a password is sixteen words, all supplied by the host and checked as a set.
// - loading the system-programming instruction invokes the bootstrap loader.
// - setting system_program_enable during reset makes the device leave reset in the loader.
// - the loader may clear system_program_enable and reset, so the application starts.
// - test-port writes to privilege registers are blocked unless protection is disabled.
// - test-port memory accesses to the system area are rejected unless protection is off.
// - all debug services are denied while the cpu executes in the system area.
// - debug mode halts the cpu, reads and writes registers and memory, and single-steps.
// - background mode leaves the cpu running while the host sets up the debugger.
// - breakpoints on register, code or data hand control to debug service routines in rom.
// - host and device talk over a dedicated five-wire (tck, tms, tdi, tdo and test reset) synchronous boundary-scan port.
`include "jdbl_defines.vh"
module jdbl_top
(
  input  wire        i_clk,
  input  wire        i_reset_n,
  input  wire        i_tck,
  input  wire        i_tms,
  input  wire        i_tdi,
  input  wire        i_trst_n,
  output reg         o_tdo,
  output reg         o_tdo_oe,
  input  wire        i_cpu_in_reset,
  input  wire        i_cpu_in_system_area,
  input  wire        i_protect_disable,
  input  wire        i_loader_clear_spe,
  output reg         o_system_program_enable,
  output reg         o_boot_from_loader,
  output reg         o_loader_invoke,
  input  wire [15:0] i_pw_word,
  output reg  [1:0]  o_pw_area,
  output reg  [3:0]  o_pw_index,
  output reg  [2:0]  o_area_unlock,
  output reg         o_cpu_halt,
  output reg         o_cpu_step,
  output reg         o_debug_service,
  output reg         o_dbg_req,
  output reg         o_dbg_we,
  output reg  [1:0]  o_dbg_space,
  output reg  [15:0] o_dbg_addr,
  output reg  [15:0] o_dbg_wdata,
  input  wire        i_dbg_ack,
  input  wire [15:0] i_dbg_rdata,
  input  wire        i_trace_valid,
  input  wire [1:0]  i_trace_kind,
  input  wire [15:0] i_trace_addr
);

  wire [3:0]              pins_sync;
  wire                    tck_s;
  wire                    tms_s;
  wire                    tdi_s;
  wire                    trst_n_s;
  wire [15:0]             tap_state;
  reg                     tck_d;
  reg  [`JDBL_IR_W-1:0]   ir;
  reg  [`JDBL_IR_W-1:0]   ir_sh;
  reg  [`JDBL_DR_W-1:0]   dr;
  reg                     cpu_reset_d;
  reg                     pw_cmp;
  reg                     pw_match;
  reg                     dbg_busy;
  reg                     dbg_denied;
  reg  [15:0]             dbg_rdata;
  reg  [1:0]              bp_kind;
  reg  [15:0]             bp_value;
  wire                    tck_rise;
  wire                    tck_fall;
  wire                    upd_dr;
  wire [2:0]              cmd_op;
  wire [1:0]              cmd_space;
  wire [15:0]             cmd_addr;
  wire [15:0]             cmd_data;
  wire [1:0]              pw_area_in;
  wire                    in_sys_mem;
  reg                     deny;

  jdbl_sync #(.W(4)) u_sync
  (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   ({i_tck, i_tms, i_tdi, i_trst_n}),
    .o_sync    (pins_sync)
  );

  assign tck_s    = pins_sync[3];
  assign tms_s    = pins_sync[2];
  assign tdi_s    = pins_sync[1];
  assign trst_n_s = pins_sync[0];
  assign tck_rise = tck_s & ~tck_d;
  assign tck_fall = ~tck_s & tck_d;

  jdbl_tap_fsm u_tap
  (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_adv     (tck_rise),
    .i_tms     (tms_s),
    .i_trst_n  (trst_n_s),
    .o_state   (tap_state)
  );

  // update actions happen on the rising edge that leaves update-dr
  assign upd_dr     = tck_rise && (tap_state == `JDBL_ST_UPD_DR);
  assign cmd_op     = dr[36:34];
  assign cmd_space  = dr[33:32];
  assign cmd_addr   = dr[31:16];
  assign cmd_data   = dr[15:0];
  assign pw_area_in = dr[17:16];
  assign in_sys_mem = (cmd_addr >= `JDBL_SYS_BASE) && (cmd_addr <= `JDBL_SYS_LIMIT);

  // decide whether the debug command just updated may proceed
  always @*
  begin
    deny = 1'b0;
    if (i_cpu_in_system_area)
      deny = 1'b1;
    else if (cmd_space == `JDBL_SP_PRIV && cmd_op == `JDBL_OP_WRITE && !i_protect_disable)
      deny = 1'b1;
    else if (cmd_space == `JDBL_SP_MEM && in_sys_mem && !i_protect_disable &&
             (cmd_op == `JDBL_OP_READ || cmd_op == `JDBL_OP_WRITE))
      deny = 1'b1;
    else if (!o_cpu_halt && cmd_space != `JDBL_SP_BREAK &&
             (cmd_op == `JDBL_OP_READ || cmd_op == `JDBL_OP_WRITE ||
              cmd_op == `JDBL_OP_STEP))
      deny = 1'b1;
  end

  // test port: instruction and data shifting, tdo on falling edge
  always @(posedge i_clk)
  begin
    if (!i_reset_n || !trst_n_s)
    begin
      tck_d    <= 1'b0;
      ir       <= `JDBL_IR_BYPASS;
      ir_sh    <= {`JDBL_IR_W{1'b0}};
      dr       <= {`JDBL_DR_W{1'b0}};
      o_tdo    <= 1'b0;
      o_tdo_oe <= 1'b0;
    end
    else
    begin
      tck_d <= tck_s;
      if (tck_rise)
      begin
        case (tap_state)
          `JDBL_ST_TLR:    ir <= `JDBL_IR_BYPASS;
          `JDBL_ST_CAP_IR: ir_sh <= `JDBL_IR_CAPTURE;
          `JDBL_ST_SH_IR:  ir_sh <= {tdi_s, ir_sh[`JDBL_IR_W-1:1]};
          `JDBL_ST_UPD_IR: ir <= ir_sh;
          `JDBL_ST_CAP_DR:
          begin
            case (ir)
              `JDBL_IR_SPE:      dr <= {36'h0, o_system_program_enable};
              `JDBL_IR_PASSWORD: dr <= {34'h0, o_area_unlock};
              `JDBL_IR_DEBUG:    dr <= {2'b00, dbg_busy, dbg_denied, o_cpu_halt,
                                        16'h0000, dbg_rdata};
              default:           dr <= {`JDBL_DR_W{1'b0}};
            endcase
          end
          `JDBL_ST_SH_DR:
          begin
            case (ir)
              `JDBL_IR_PASSWORD: dr <= {19'h0, tdi_s, dr[`JDBL_PW_LEN-1:1]};
              `JDBL_IR_DEBUG:    dr <= {tdi_s, dr[`JDBL_DR_W-1:1]};
              default:           dr <= {36'h0, tdi_s};
            endcase
          end
          default:         ir <= ir;
        endcase
      end
      if (tck_fall)
      begin
        o_tdo    <= (tap_state == `JDBL_ST_SH_IR) ? ir_sh[0] : dr[0];
        o_tdo_oe <= (tap_state == `JDBL_ST_SH_IR) || (tap_state == `JDBL_ST_SH_DR);
      end
    end
  end

  // loader entry through the system-program flag
  always @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      cpu_reset_d             <= 1'b0;
      o_system_program_enable <= 1'b0;
      o_boot_from_loader      <= 1'b0;
      o_loader_invoke         <= 1'b0;
    end
    else
    begin
      cpu_reset_d <= i_cpu_in_reset;
      o_loader_invoke <= tck_rise && (tap_state == `JDBL_ST_UPD_IR) &&
                         (ir_sh == `JDBL_IR_SYSPROG);
      if (upd_dr && ir == `JDBL_IR_SPE && i_cpu_in_reset)
        o_system_program_enable <= dr[0];
      else if (i_loader_clear_spe)
        o_system_program_enable <= 1'b0;
      if (cpu_reset_d && !i_cpu_in_reset)
        o_boot_from_loader <= o_system_program_enable;
    end
  end

  // password check: latch a word, compare it next cycle against memory
  always @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      o_pw_area     <= `JDBL_AREA_NONE;
      o_pw_index    <= 4'h0;
      o_area_unlock <= 3'b000;
      o_dbg_wdata   <= 16'h0000;
      pw_cmp        <= 1'b0;
      pw_match      <= 1'b1;
    end
    else
    begin
      pw_cmp <= 1'b0;
      if (upd_dr && ir == `JDBL_IR_PASSWORD && pw_area_in != `JDBL_AREA_NONE)
      begin
        pw_cmp <= 1'b1;
        if (pw_area_in != o_pw_area)
        begin
          o_pw_area  <= pw_area_in;
          o_pw_index <= 4'h0;
          pw_match   <= 1'b1;
        end
        o_dbg_wdata <= cmd_data;
      end
      else if (upd_dr && ir == `JDBL_IR_DEBUG)
        o_dbg_wdata <= cmd_data;
      if (pw_cmp)
      begin
        if (o_pw_index == `JDBL_PW_LAST)
        begin
          if (pw_match && i_pw_word == o_dbg_wdata)
            o_area_unlock[o_pw_area] <= 1'b1;
          o_pw_index <= 4'h0;
          pw_match   <= 1'b1;
        end
        else
        begin
          o_pw_index <= o_pw_index + 4'h1;
          pw_match   <= pw_match && (i_pw_word == o_dbg_wdata);
        end
      end
    end
  end

  // debug engine: commands, accesses, modes and breakpoints
  always @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      o_cpu_halt      <= 1'b0;
      o_cpu_step      <= 1'b0;
      o_debug_service <= 1'b0;
      o_dbg_req       <= 1'b0;
      o_dbg_we        <= 1'b0;
      o_dbg_space     <= `JDBL_SP_REG;
      o_dbg_addr      <= 16'h0000;
      dbg_busy        <= 1'b0;
      dbg_denied      <= 1'b0;
      dbg_rdata       <= 16'h0000;
      bp_kind         <= `JDBL_BP_OFF;
      bp_value        <= 16'h0000;
    end
    else
    begin
      o_dbg_req       <= 1'b0;
      o_cpu_step      <= 1'b0;
      o_debug_service <= 1'b0;
      if (i_dbg_ack && dbg_busy)
      begin
        dbg_busy <= 1'b0;
        if (!o_dbg_we)
          dbg_rdata <= i_dbg_rdata;
      end
      if (i_trace_valid && !o_cpu_halt && bp_kind != `JDBL_BP_OFF && !i_cpu_in_system_area &&
          i_trace_kind == bp_kind && i_trace_addr == bp_value)
      begin
        o_cpu_halt      <= 1'b1;
        o_debug_service <= 1'b1;
      end
      else if (upd_dr && ir == `JDBL_IR_DEBUG && cmd_op != `JDBL_OP_NOP && !dbg_busy)
      begin
        dbg_denied <= deny;
        if (!deny)
        begin
          case (cmd_op)
            `JDBL_OP_HALT:   o_cpu_halt <= 1'b1;
            `JDBL_OP_RESUME: o_cpu_halt <= 1'b0;
            `JDBL_OP_STEP:   o_cpu_step <= 1'b1;
            `JDBL_OP_READ,
            `JDBL_OP_WRITE:
            begin
              if (cmd_space == `JDBL_SP_BREAK)
              begin
                bp_kind  <= cmd_addr[1:0];
                bp_value <= cmd_data;
              end
              else
              begin
                o_dbg_req   <= 1'b1;
                o_dbg_we    <= (cmd_op == `JDBL_OP_WRITE);
                o_dbg_space <= cmd_space;
                o_dbg_addr  <= cmd_addr;
                dbg_busy    <= 1'b1;
              end
            end
            default:         o_cpu_halt <= o_cpu_halt;
          endcase
        end
      end
    end
  end

endmodule // jdbl_top

// *** tb/jdbl_assertions.sv ***
// jdbl_assertions.sv: port-level checks of jdbl_top
// assumes: bound to jdbl_top; everything on i_clk, reset synchronous active low
`include "jdbl_defines.vh"
module jdbl_assertions
(
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic        i_cpu_in_reset,
  input wire logic        i_cpu_in_system_area,
  input wire logic        i_protect_disable,
  input wire logic        o_system_program_enable,
  input wire logic        o_boot_from_loader,
  input wire logic        o_loader_invoke,
  input wire logic [3:0]  o_pw_index,
  input wire logic [2:0]  o_area_unlock,
  input wire logic        o_cpu_halt,
  input wire logic        o_cpu_step,
  input wire logic        o_debug_service,
  input wire logic        o_dbg_req,
  input wire logic        o_dbg_we,
  input wire logic [1:0]  o_dbg_space,
  input wire logic [15:0] o_dbg_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  chk_unlock_sticky: assert property (
    (o_area_unlock & $past(o_area_unlock)) == $past(o_area_unlock))
    else $error("area unlock bit dropped");
  chk_unlock_last_word: assert property (
    (o_area_unlock & ~$past(o_area_unlock)) != 3'h0 |-> $past(o_pw_index) == 4'hf)
    else $error("area unlocked before sixteenth word");
  chk_spe_in_reset: assert property (
    $rose(o_system_program_enable) |-> $past(i_cpu_in_reset))
    else $error("program enable set outside cpu reset");
  chk_boot_follows_flag: assert property (
    $fell(i_cpu_in_reset) |-> ##3 o_boot_from_loader == $past(o_system_program_enable, 3))
    else $error("boot choice does not follow program enable");
  chk_priv_guard: assert property (
    o_dbg_req && o_dbg_we && o_dbg_space == `JDBL_SP_PRIV |-> $past(i_protect_disable))
    else $error("privilege write while protected");
  chk_sysmem_guard: assert property (
    o_dbg_req && o_dbg_space == `JDBL_SP_MEM && o_dbg_addr >= `JDBL_SYS_BASE
    && o_dbg_addr <= `JDBL_SYS_LIMIT |-> $past(i_protect_disable))
    else $error("system memory access while protected");
  chk_sys_area_deny: assert property (
    $past(i_cpu_in_system_area) |-> !(o_dbg_req || o_cpu_step || o_debug_service))
    else $error("debug service in system area");
  chk_step_halted: assert property (
    o_cpu_step |-> $past(o_cpu_halt))
    else $error("step outside debug mode");
  chk_req_pulse: assert property (
    o_dbg_req |=> !o_dbg_req)
    else $error("access request longer than one cycle");
  chk_bp_service: assert property (
    o_debug_service |=> o_cpu_halt && !o_debug_service)
    else $error("service entry without halt");
  chk_invoke_pulse: assert property (
    o_loader_invoke |=> !o_loader_invoke)
    else $error("loader invoke longer than one cycle");
endmodule // jdbl_assertions

bind jdbl_top jdbl_assertions i_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_cpu_in_reset(i_cpu_in_reset), .i_cpu_in_system_area(i_cpu_in_system_area),
  .i_protect_disable(i_protect_disable), .o_system_program_enable(o_system_program_enable),
  .o_boot_from_loader(o_boot_from_loader), .o_loader_invoke(o_loader_invoke),
  .o_pw_index(o_pw_index), .o_area_unlock(o_area_unlock), .o_cpu_halt(o_cpu_halt),
  .o_cpu_step(o_cpu_step), .o_debug_service(o_debug_service), .o_dbg_req(o_dbg_req),
  .o_dbg_we(o_dbg_we), .o_dbg_space(o_dbg_space), .o_dbg_addr(o_dbg_addr));

// *** tb/jdbl_host.sv ***
// jdbl_host.sv: test-port host model driving the three test pins tck, tms and tdi
// assumes: bench calls its tasks; tck stands low between frames
module jdbl_host
(
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi,
  input  wire logic i_tdo,
  input  wire logic i_tdo_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last = 1'b0;
  initial
  begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  // one test clock of 125 ns; released tdo reads as the inverse of its last level
  task automatic bit_io(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #62.5;
    if (i_tdo_oe)
      last = i_tdo;
    tdo = i_tdo_oe ? i_tdo : ~last;
    o_tck = 1'b1;
    #62.5;
    o_tck = 1'b0;
  endtask
  task automatic reset_tap();
    logic t;
    repeat (5) bit_io(1'b1, 1'b0, t);
    bit_io(1'b0, 1'b0, t);
  endtask
  // from idle: select, capture, shift n bits lsb first, exit, update, idle
  task automatic shift(input logic ir, input int n, input logic [36:0] d,
                       output logic [36:0] q);
    logic t;
    q = '0;
    bit_io(1'b1, 1'b0, t);
    if (ir)
      bit_io(1'b1, 1'b0, t);
    bit_io(1'b0, 1'b0, t);
    bit_io(1'b0, 1'b0, t);
    for (int i = 0; i < n; i++)
    begin
      bit_io(i == n - 1, d[i], t);
      q[i] = t;
    end
    bit_io(1'b1, 1'b0, t);
    bit_io(1'b0, 1'b0, t);
  endtask
endmodule // jdbl_host

// *** tb/tb.sv ***
// tb.sv: self-checking bench of the test-port debug and loader block
// assumes: host model drives test pins; bench plays cpu, password store and debug bus
`include "jdbl_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_clk = 1'b0, i_reset_n = 1'b0, i_tck, i_tms, i_tdi, i_trst_n = 1'b1;
  logic        i_cpu_in_reset = 1'b0, i_cpu_in_system_area = 1'b0, i_protect_disable = 1'b0;
  logic        i_loader_clear_spe = 1'b0, i_dbg_ack = 1'b0, i_trace_valid = 1'b0;
  logic [1:0]  i_trace_kind = 2'h0;
  logic [15:0] i_trace_addr = 16'h0, i_dbg_rdata = 16'h0, i_pw_word;
  logic        o_tdo, o_tdo_oe, o_system_program_enable, o_boot_from_loader, o_loader_invoke;
  logic        o_cpu_halt, o_cpu_step, o_debug_service, o_dbg_req, o_dbg_we;
  logic [1:0]  o_pw_area, o_dbg_space;
  logic [3:0]  o_pw_index;
  logic [2:0]  o_area_unlock;
  logic [15:0] o_dbg_addr, o_dbg_wdata;
  logic [36:0] q;
  int          n_mismatch = 0, checked = 0, n_inv = 0, n_step = 0, n_svc = 0, n_req = 0;

  jdbl_top i_jdbl_top (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_tck(i_tck), .i_tms(i_tms),
    .i_tdi(i_tdi), .i_trst_n(i_trst_n), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe),
    .i_cpu_in_reset(i_cpu_in_reset), .i_cpu_in_system_area(i_cpu_in_system_area),
    .i_protect_disable(i_protect_disable), .i_loader_clear_spe(i_loader_clear_spe),
    .o_system_program_enable(o_system_program_enable), .o_boot_from_loader(o_boot_from_loader),
    .o_loader_invoke(o_loader_invoke), .i_pw_word(i_pw_word), .o_pw_area(o_pw_area),
    .o_pw_index(o_pw_index), .o_area_unlock(o_area_unlock), .o_cpu_halt(o_cpu_halt),
    .o_cpu_step(o_cpu_step), .o_debug_service(o_debug_service), .o_dbg_req(o_dbg_req),
    .o_dbg_we(o_dbg_we), .o_dbg_space(o_dbg_space), .o_dbg_addr(o_dbg_addr),
    .o_dbg_wdata(o_dbg_wdata), .i_dbg_ack(i_dbg_ack), .i_dbg_rdata(i_dbg_rdata),
    .i_trace_valid(i_trace_valid), .i_trace_kind(i_trace_kind), .i_trace_addr(i_trace_addr));
  jdbl_host i_jdbl_host (.o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi), .i_tdo(o_tdo),
    .i_tdo_oe(o_tdo_oe));

  always #5 i_clk = ~i_clk;

  function automatic logic [15:0] pw(input logic [1:0] a, input logic [3:0] k);
    return {a, 10'h2a5, k};
  endfunction
  assign i_pw_word = pw(o_pw_area, o_pw_index);

  always @(posedge i_clk)
  begin
    n_inv <= n_inv + o_loader_invoke;
    n_step <= n_step + o_cpu_step;
    n_svc <= n_svc + o_debug_service;
    n_req <= n_req + o_dbg_req;
  end
  // debug bus answers one cycle after each request
  always @(negedge i_clk)
  begin
    i_dbg_ack <= o_dbg_req;
    i_dbg_rdata <= o_dbg_addr ^ 16'h3c3c;
  end

  task automatic chk(input logic [36:0] got, input logic [36:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic setir(input logic [3:0] code);
    i_jdbl_host.shift(1'b1, 4, {33'h0, code}, q);
    wait_clk(6);
    chk(q[3:0], 4'h1);
  endtask
  task automatic dr(input int n, input logic [36:0] d);
    i_jdbl_host.shift(1'b0, n, d, q);
    wait_clk(6);
  endtask
  task automatic dbg(input logic [36:0] cmd, input int exp_req);
    int r;
    r = n_req;
    dr(37, cmd);
    chk(n_req - r, exp_req);
  endtask

  task automatic test_boot();
    int r;
    r = n_inv;
    setir(`JDBL_IR_SYSPROG);
    chk(n_inv - r, 1);
    setir(`JDBL_IR_SPE);
    dr(1, 37'h1);
    chk(o_system_program_enable, 1'b0);
    i_cpu_in_reset = 1'b1;
    dr(1, 37'h1);
    chk(o_system_program_enable, 1'b1);
    i_cpu_in_reset = 1'b0;
    wait_clk(5);
    chk(o_boot_from_loader, 1'b1);
    i_loader_clear_spe = 1'b1;
    i_cpu_in_reset = 1'b1;
    wait_clk(1);
    i_loader_clear_spe = 1'b0;
    wait_clk(2);
    i_cpu_in_reset = 1'b0;
    wait_clk(5);
    chk({o_system_program_enable, o_boot_from_loader}, 2'h0);
  endtask

  // area 1 gets one wrong word and must stay locked
  task automatic test_pw();
    logic [2:0] exp;
    exp = 3'h0;
    setir(`JDBL_IR_PASSWORD);
    for (int a = 0; a < 3; a++)
    begin
      for (int i = 0; i < 16; i++)
      begin
        if (i == 15)
          chk(o_area_unlock, exp);
        dr(18, {19'h0, a[1:0], pw(a[1:0], i[3:0]) ^ {15'h0, a == 1 && i == 7}});
      end
      if (a != 1)
        exp[a] = 1'b1;
      chk(o_area_unlock, exp);
    end
    chk({o_pw_area, o_pw_index}, {`JDBL_AREA_APP, 4'h0});
  endtask

  task automatic trace(input logic [1:0] kind);
    i_trace_kind = kind;
    i_trace_addr = 16'h1234;
    i_trace_valid = 1'b1;
    wait_clk(1);
    i_trace_valid = 1'b0;
    wait_clk(4);
  endtask

  task automatic test_dbg();
    int r;
    setir(`JDBL_IR_DEBUG);
    dbg({`JDBL_OP_READ, `JDBL_SP_REG, 32'h0}, 0);
    dbg({`JDBL_OP_HALT, 34'h0}, 0);
    chk(o_cpu_halt, 1'b1);
    dbg({`JDBL_OP_READ, `JDBL_SP_REG, 16'h0003, 16'h0}, 1);
    dbg({`JDBL_OP_READ, `JDBL_SP_MEM, 16'h0100, 16'h0}, 1);
    dbg({`JDBL_OP_NOP, 34'h0}, 0);
    chk(q[33:0], {2'h1, 16'h0, 16'h0100 ^ 16'h3c3c});
    for (int p = 0; p < 2; p++)
    begin
      i_protect_disable = p[0];
      dbg({`JDBL_OP_WRITE, `JDBL_SP_MEM, 16'h8000, 16'h5555}, p);
      dbg({`JDBL_OP_READ, `JDBL_SP_MEM, 16'h9fff, 16'h0}, p);
      dbg({`JDBL_OP_WRITE, `JDBL_SP_PRIV, 16'h0004, 16'h00ff}, p);
    end
    chk({o_dbg_we, o_dbg_space, o_dbg_addr, o_dbg_wdata}, {1'b1, `JDBL_SP_PRIV, 32'h000400ff});
    i_protect_disable = 1'b0;
    dbg({`JDBL_OP_READ, `JDBL_SP_MEM, 16'ha000, 16'h0}, 1);
    r = n_step;
    dr(37, {`JDBL_OP_STEP, 34'h0});
    chk(n_step - r, 1);
    i_cpu_in_system_area = 1'b1;
    dbg({`JDBL_OP_READ, `JDBL_SP_REG, 32'h0}, 0);
    dr(37, {`JDBL_OP_STEP, 34'h0});
    dr(37, {`JDBL_OP_RESUME, 34'h0});
    chk({n_step - r, o_cpu_halt}, {32'h1, 1'b1});
    i_cpu_in_system_area = 1'b0;
    dr(37, {`JDBL_OP_RESUME, 34'h0});
    chk(o_cpu_halt, 1'b0);
    r = n_svc;
    dr(37, {`JDBL_OP_WRITE, `JDBL_SP_BREAK, 16'h0001, 16'h1234});
    trace(2'h2);
    chk({n_svc - r, o_cpu_halt}, {32'h0, 1'b0});
    i_cpu_in_system_area = 1'b1;
    trace(2'h1);
    i_cpu_in_system_area = 1'b0;
    chk({n_svc - r, o_cpu_halt}, {32'h0, 1'b0});
    trace(2'h1);
    chk({n_svc - r, o_cpu_halt}, {32'h1, 1'b1});
  endtask

  // test reset puts the port back to bypass; flags and halt stay
  task automatic test_trst();
    i_trst_n = 1'b0;
    wait_clk(4);
    i_trst_n = 1'b1;
    wait_clk(4);
    i_jdbl_host.reset_tap();
    dr(37, {`JDBL_OP_RESUME, 34'h0});
    chk({o_cpu_halt, q}, {1'b1, 2'h1, 35'h0});
  endtask

  task automatic test_done();
    if (n_mismatch == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #700000;
    n_mismatch++;
    test_done();
  end
  initial
  begin
    wait_clk(2);
    i_reset_n = 1'b1;
    wait_clk(4);
    i_jdbl_host.reset_tap();
    wait_clk(4);
    chk(o_tdo_oe, 1'b0);
    test_boot();
    test_pw();
    test_dbg();
    test_trst();
    test_done();
  end
endmodule // tb
